// ===== design/sdram_opm_pkg.sv
// Package with register map, field layout and encodings of the SDRAM operation mode block.
package sdram_opm_pkg;

    localparam logic [31:0] OPMODE_ADDR   = 32'h1E00_0040;
    localparam logic [31:0] ECCMODE_ADDR  = 32'h1E00_0050;
    localparam logic [31:0] ERRSTAT_ADDR  = 32'h1E00_0060;
    localparam logic [31:0] ERRADDR_ADDR  = 32'h1E00_0070;
    localparam int          SLOT_LSB      = 4;
    localparam logic [1:0]  WORD0         = 2'h0;

    localparam int          OPSEL_LSB     = 0;
    localparam int          STATE_LSB     = 10;
    localparam int          ECC_MODE_SELECT_LSB      = 0;
    localparam int          SINGLE_ERROR_IRQ_ENABLE_BIT      = 3;
    localparam int          MULTI_ERROR_IRQ_ENABLE_BIT      = 4;
    localparam int          CHECK_LSB     = 8;
    localparam int          SBE_BIT       = 0;
    localparam int          MBE_BIT       = 1;
    localparam int          SYND_LSB      = 16;
    localparam int          ERRADDR_LSB   = 4;

    localparam logic [31:0] OPM_WR_MASK   = 32'h0000_0007;
    localparam logic [31:0] ECC_WR_MASK   = 32'h0000_FF1F;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [12:0] ZERO_ROW      = 13'h0000;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;

    typedef enum logic [2:0] {
        OP_NORMAL     = 3'h0,
        OP_NOP        = 3'h1,
        OP_PRECHARGE  = 3'h2,
        OP_MODE_WRITE = 3'h3,
        OP_REFRESH    = 3'h4
    } op_t;

    typedef enum logic [2:0] {
        ECC_OFF     = 3'h0,
        ECC_DETECT  = 3'h1,
        ECC_CORRECT = 3'h2,
        ECC_DIAG    = 3'h3
    } ecc_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'h0,
        ST_ACTIVATE   = 3'h1,
        ST_PRECHARGE  = 3'h2,
        ST_MODE_WRITE = 3'h3,
        ST_REFRESH    = 3'h4,
        ST_READ       = 3'h5,
        ST_WRITE      = 3'h6
    } seq_state_t;

    typedef enum logic [2:0] {
        CMD_NOP           = 3'h0,
        CMD_ACTIVATE      = 3'h1,
        CMD_READ          = 3'h2,
        CMD_WRITE         = 3'h3,
        CMD_PRECHARGE_ALL = 3'h4,
        CMD_MODE_SET      = 3'h5,
        CMD_REFRESH       = 3'h6
    } sdram_cmd_t;

    localparam logic [2:0]  OPSEL_RESET   = OP_NOP;
    localparam logic [2:0]  ECC_MODE_SELECT_RESET    = ECC_OFF;

endpackage

// ===== design/seq_if.sv
// Interface between the register block and the command sequencer.
`timescale 1ns/10ps
`default_nettype none
interface seq_if;
    import sdram_opm_pkg::*;
    logic [2:0]  op_sel;
    logic        req;
    logic        write;
    logic        ready;
    logic [1:0]  dimm;
    logic [1:0]  bank;
    logic [12:0] row;
    seq_state_t  state;
    logic        cmd_valid;
    sdram_cmd_t  cmd;
    logic [1:0]  cmd_dimm;
    logic [1:0]  cmd_bank;
    logic [12:0] cmd_addr;

    modport ctrl (output op_sel, req, write, dimm, bank, row,
                  input  ready, state, cmd_valid, cmd, cmd_dimm, cmd_bank, cmd_addr);
    modport seq  (input  op_sel, req, write, dimm, bank, row,
                  output ready, state, cmd_valid, cmd, cmd_dimm, cmd_bank, cmd_addr);
endinterface
`default_nettype wire

// ===== design/op_sequencer.sv
// Command sequencer that turns DIMM accesses into SDRAM commands by operation mode.
`timescale 1ns/10ps
`default_nettype none
module op_sequencer
    import sdram_opm_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic ce_in,
    // Link to the register block.
    seq_if.seq        bus
);

    seq_state_t  state;
    seq_state_t  next_state;
    logic        write_q;
    logic        accept;

    assign bus.ready = (state == ST_IDLE);
    assign bus.state = state;
    assign accept    = bus.req && bus.ready;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    case (bus.op_sel)
                        OP_NORMAL:     next_state = ST_ACTIVATE;
                        OP_PRECHARGE:  next_state = bus.write ? ST_PRECHARGE : ST_IDLE;
                        OP_MODE_WRITE: next_state = bus.write ? ST_MODE_WRITE : ST_IDLE;
                        OP_REFRESH:    next_state = bus.write ? ST_REFRESH : ST_IDLE;
                        default:       next_state = ST_IDLE;
                    endcase
                end
            end
            ST_ACTIVATE: next_state = write_q ? ST_WRITE : ST_READ;
            default:     next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            write_q <= 1'b0;
        end else if (ce_in && accept) begin
            write_q <= bus.write;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bus.cmd_valid <= 1'b0;
            bus.cmd       <= CMD_NOP;
            bus.cmd_dimm  <= 2'h0;
            bus.cmd_bank  <= 2'h0;
            bus.cmd_addr  <= ZERO_ROW;
        end else if (ce_in) begin
            bus.cmd_valid <= 1'b0;
            if (state == ST_IDLE && accept) begin
                bus.cmd_dimm <= bus.dimm;
                bus.cmd_bank <= bus.bank;
                bus.cmd_addr <= ZERO_ROW;
                case (bus.op_sel)
                    OP_NORMAL: begin
                        bus.cmd_valid <= 1'b1;
                        bus.cmd       <= CMD_ACTIVATE;
                        bus.cmd_addr  <= bus.row;
                    end
                    OP_NOP: begin
                        bus.cmd_valid <= 1'b1;
                        bus.cmd       <= CMD_NOP;
                    end
                    OP_PRECHARGE: begin
                        bus.cmd_valid <= bus.write;
                        bus.cmd       <= CMD_PRECHARGE_ALL;
                    end
                    OP_MODE_WRITE: begin
                        bus.cmd_valid <= bus.write;
                        bus.cmd       <= CMD_MODE_SET;
                        bus.cmd_addr  <= bus.row;
                    end
                    OP_REFRESH: begin
                        bus.cmd_valid <= bus.write;
                        bus.cmd       <= CMD_REFRESH;
                    end
                    default: begin
                        bus.cmd_valid <= 1'b0;
                    end
                endcase
            end else if (state == ST_ACTIVATE) begin
                bus.cmd_valid <= 1'b1;
                bus.cmd       <= write_q ? CMD_WRITE : CMD_READ;
                bus.cmd_addr  <= ZERO_ROW;
            end
        end
    end

endmodule
`default_nettype wire

// ===== design/sdram_op_mode_ctrl.sv
// Operation mode and ECC mode control of an SDRAM controller, with APB register access.
//
// Functional notes
// - Operation select field decodes normal, NOP, precharge, mode write, refresh; resets NOP.
// - Read-only state field shows idle, activate, precharge, mode write, refresh, read, write.
// - Special command is launched by a dummy DIMM write after selecting the operation.
// - Mode register write loads row address of the dummy write, not data.
// - With NOP selected, any DIMM access produces only NOP commands.
// - With precharge selected, each DIMM write precharges all banks of that DIMM.
// - A bank is activated before any read or write to it.
// - With refresh selected, each DIMM write issues one auto-refresh, address ignored.
// - ECC mode field selects off, detect, correct or diagnostic; resets to zero.
// - Diagnostic mode writes the programmed check byte instead of generated bits.
// - Single and multiple error interrupts each gated by an enable bit.
// - Error status and address capture every error regardless of enables.
// - Each register sits in a 16-byte slot; only its first word holds data.
`timescale 1ns/10ps
`default_nettype none
module sdram_op_mode_ctrl
    import sdram_opm_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // APB slave.
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Memory access from the system.
    input  wire logic        mem_req_in,
    input  wire logic        mem_write_in,
    input  wire logic [1:0]  mem_dimm_in,
    input  wire logic [1:0]  mem_bank_in,
    input  wire logic [12:0] mem_row_in,
    output logic             mem_ready_out,
    // SDRAM command.
    output logic             cmd_valid_out,
    output logic      [2:0]  cmd_out,
    output logic      [1:0]  cmd_dimm_out,
    output logic      [1:0]  cmd_bank_out,
    output logic      [12:0] cmd_addr_out,
    // ECC datapath.
    input  wire logic [7:0]  ecc_gen_check_in,
    input  wire logic        ecc_single_err_in,
    input  wire logic        ecc_multi_err_in,
    input  wire logic [7:0]  ecc_err_check_in,
    input  wire logic [7:0]  ecc_syndrome_in,
    input  wire logic [31:0] ecc_err_addr_in,
    output logic             ecc_gen_en_out,
    output logic             ecc_detect_en_out,
    output logic             ecc_correct_en_out,
    output logic      [7:0]  ecc_wr_check_out,
    output logic             ecc_irq_out
);

    seq_if bus ();

    logic [2:0]  op_sel;
    logic [2:0]  ecc_mode;
    logic        single_err_irq_enable;
    logic        multi_err_irq_enable;
    logic [7:0]  diag_check;
    logic        err_sbe;
    logic        err_mbe;
    logic [7:0]  err_check;
    logic [7:0]  err_synd;
    logic [27:0] err_addr;
    logic [31:0] opm_word;
    logic [31:0] ecc_word;
    logic [31:0] stat_word;
    logic [31:0] next_prdata;
    logic        setup;
    logic        wr_access;
    logic        rd_access;
    logic        stat_clear;
    logic        accept;
    logic [31:0] opm_merged;
    logic [31:0] ecc_merged;

    function automatic logic slot_hit(input logic [31:0] addr, input logic [31:0] base);
        slot_hit = (addr[31:SLOT_LSB] == base[31:SLOT_LSB]);
    endfunction

    function automatic logic word_hit(input logic [31:0] addr, input logic [31:0] base);
        word_hit = slot_hit(addr, base) && (addr[3:2] == WORD0);
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] merged;
        merged = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        apply_strb = merged & mask;
    endfunction

    assign setup      = psel_in && !penable_in;
    assign wr_access  = ce_in && psel_in && penable_in && pwrite_in;
    assign rd_access  = ce_in && psel_in && penable_in && !pwrite_in;
    assign stat_clear = rd_access && word_hit(paddr_in, ERRSTAT_ADDR);
    assign pready_out = 1'b1;
    assign opm_merged = apply_strb(opm_word, pwdata_in, pstrb_in, OPM_WR_MASK);
    assign ecc_merged = apply_strb(ecc_word, pwdata_in, pstrb_in, ECC_WR_MASK);

    assign bus.op_sel  = op_sel;
    assign bus.req     = mem_req_in;
    assign bus.write   = mem_write_in;
    assign bus.dimm    = mem_dimm_in;
    assign bus.bank    = mem_bank_in;
    assign bus.row     = mem_row_in;
    assign mem_ready_out = bus.ready;
    assign accept        = mem_req_in && bus.ready;
    assign cmd_valid_out = bus.cmd_valid;
    assign cmd_out       = bus.cmd;
    assign cmd_dimm_out  = bus.cmd_dimm;
    assign cmd_bank_out  = bus.cmd_bank;
    assign cmd_addr_out  = bus.cmd_addr;

    op_sequencer u_seq (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .ce_in       (ce_in),
        .bus         (bus.seq)
    );

    always_comb begin
        opm_word = ZERO_WORD;
        opm_word[OPSEL_LSB +: 3] = op_sel;
        opm_word[STATE_LSB +: 3] = bus.state;
        ecc_word = ZERO_WORD;
        ecc_word[ECC_MODE_SELECT_LSB +: 3]  = ecc_mode;
        ecc_word[SINGLE_ERROR_IRQ_ENABLE_BIT]       = single_err_irq_enable;
        ecc_word[MULTI_ERROR_IRQ_ENABLE_BIT]       = multi_err_irq_enable;
        ecc_word[CHECK_LSB +: 8] = diag_check;
        stat_word = ZERO_WORD;
        stat_word[SBE_BIT]        = err_sbe;
        stat_word[MBE_BIT]        = err_mbe;
        stat_word[CHECK_LSB +: 8] = err_check;
        stat_word[SYND_LSB +: 8]  = err_synd;
    end

    always_comb begin
        next_prdata = ZERO_WORD;
        if (word_hit(paddr_in, OPMODE_ADDR)) begin
            next_prdata = opm_word;
        end else if (word_hit(paddr_in, ECCMODE_ADDR)) begin
            next_prdata = ecc_word;
        end else if (word_hit(paddr_in, ERRSTAT_ADDR)) begin
            next_prdata = stat_word;
        end else if (word_hit(paddr_in, ERRADDR_ADDR)) begin
            next_prdata = {err_addr, 4'h0};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            prdata_out  <= ZERO_WORD;
            pslverr_out <= 1'b0;
        end else if (ce_in && setup) begin
            prdata_out  <= next_prdata;
            pslverr_out <= !(slot_hit(paddr_in, OPMODE_ADDR) || slot_hit(paddr_in, ECCMODE_ADDR) ||
                             slot_hit(paddr_in, ERRSTAT_ADDR) || slot_hit(paddr_in, ERRADDR_ADDR));
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            op_sel <= OPSEL_RESET;
        end else if (wr_access && word_hit(paddr_in, OPMODE_ADDR)) begin
            op_sel <= opm_merged[OPSEL_LSB +: 3];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ecc_mode              <= ECC_MODE_SELECT_RESET;
            single_err_irq_enable <= 1'b0;
            multi_err_irq_enable  <= 1'b0;
            diag_check            <= ZERO_BYTE;
        end else if (wr_access && word_hit(paddr_in, ECCMODE_ADDR)) begin
            ecc_mode              <= ecc_merged[ECC_MODE_SELECT_LSB +: 3];
            single_err_irq_enable <= ecc_merged[SINGLE_ERROR_IRQ_ENABLE_BIT];
            multi_err_irq_enable  <= ecc_merged[MULTI_ERROR_IRQ_ENABLE_BIT];
            diag_check            <= ecc_merged[CHECK_LSB +: 8];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ecc_gen_en_out     <= 1'b0;
            ecc_detect_en_out  <= 1'b0;
            ecc_correct_en_out <= 1'b0;
            ecc_wr_check_out   <= ZERO_BYTE;
        end else if (ce_in) begin
            ecc_gen_en_out     <= (ecc_mode == ECC_DETECT) || (ecc_mode == ECC_CORRECT);
            ecc_detect_en_out  <= (ecc_mode == ECC_DETECT) || (ecc_mode == ECC_CORRECT) ||
                                  (ecc_mode == ECC_DIAG);
            ecc_correct_en_out <= (ecc_mode == ECC_CORRECT);
            ecc_wr_check_out   <= (ecc_mode == ECC_DIAG) ? diag_check : ecc_gen_check_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            err_sbe <= 1'b0;
            err_mbe <= 1'b0;
        end else if (ce_in) begin
            err_sbe <= ecc_single_err_in || (err_sbe && !stat_clear);
            err_mbe <= ecc_multi_err_in || (err_mbe && !stat_clear);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            err_check <= ZERO_BYTE;
            err_synd  <= ZERO_BYTE;
            err_addr  <= 28'h0000000;
        end else if (ce_in && (ecc_single_err_in || ecc_multi_err_in)) begin
            err_check <= ecc_err_check_in;
            err_synd  <= ecc_syndrome_in;
            err_addr  <= ecc_err_addr_in[31:ERRADDR_LSB];
        end
    end

    assign ecc_irq_out = (err_sbe && single_err_irq_enable) || (err_mbe && multi_err_irq_enable);

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_opsel_write: assert property (
        wr_access && word_hit(paddr_in, OPMODE_ADDR) && pstrb_in[0]
        |=> op_sel == $past(pwdata_in[2:0]))
        else $error("operation select did not take the written code");

    a_state_read: assert property (
        ce_in && setup && word_hit(paddr_in, OPMODE_ADDR)
        |=> prdata_out[STATE_LSB +: 3] == $past(bus.state) && prdata_out[9:3] == 7'h00)
        else $error("state field read back wrong");

    a_mode_row: assert property (
        ce_in && accept && op_sel == OP_MODE_WRITE && mem_write_in
        |=> cmd_valid_out && cmd_out == CMD_MODE_SET && cmd_addr_out == $past(mem_row_in))
        else $error("mode set did not carry the row address");

    a_nop_only: assert property (
        ce_in && accept && op_sel == OP_NOP
        |=> cmd_valid_out && cmd_out == CMD_NOP ##1 (!cmd_valid_out || cmd_out == CMD_NOP || $past(op_sel) != OP_NOP))
        else $error("access in NOP mode gave a non-NOP command");

    a_prech_dimm: assert property (
        ce_in && accept && op_sel == OP_PRECHARGE && mem_write_in
        |=> cmd_valid_out && cmd_out == CMD_PRECHARGE_ALL && cmd_dimm_out == $past(mem_dimm_in))
        else $error("precharge-all not issued to the written DIMM");

    a_act_first: assert property (
        cmd_valid_out && (cmd_out == CMD_READ || cmd_out == CMD_WRITE) && $past(ce_in)
        |-> $past(cmd_valid_out) && $past(cmd_out) == CMD_ACTIVATE)
        else $error("read or write without activate before it");

    a_refresh_addr: assert property (
        ce_in && accept && op_sel == OP_REFRESH && mem_write_in
        |=> cmd_valid_out && cmd_out == CMD_REFRESH && cmd_addr_out == ZERO_ROW)
        else $error("forced refresh command wrong");

    a_ecc_off: assert property (
        ce_in && ecc_mode == ECC_OFF |=> !ecc_gen_en_out && !ecc_correct_en_out)
        else $error("check generation active with ECC off");

    a_diag_check: assert property (
        ce_in && ecc_mode == ECC_DIAG |=> ecc_wr_check_out == $past(diag_check))
        else $error("diagnostic check byte not used");

    a_irq_single: assert property (
        ce_in && ecc_single_err_in && single_err_irq_enable && !(wr_access && word_hit(paddr_in, ECCMODE_ADDR))
        |=> ecc_irq_out)
        else $error("enabled single error gave no interrupt");

    a_err_capture: assert property (
        ce_in && ecc_multi_err_in
        |=> err_mbe && err_addr == $past(ecc_err_addr_in[31:ERRADDR_LSB]))
        else $error("multiple error not captured");

    a_reserved_idle: assert property (
        ce_in && accept && op_sel > OP_REFRESH |=> !cmd_valid_out && mem_ready_out)
        else $error("reserved code launched a command");

    a_reset_fields: assert property (
        disable iff (1'b0) sys_rst_in |=> op_sel == OPSEL_RESET && ecc_mode == ECC_MODE_SELECT_RESET)
        else $error("register fields not at their reset values");

    a_special_read: assert property (
        ce_in && accept && !mem_write_in && op_sel inside {OP_PRECHARGE, OP_MODE_WRITE, OP_REFRESH}
        |=> !cmd_valid_out)
        else $error("read in a special mode launched a command");

    a_normal_busy: assert property (
        ce_in && accept && op_sel == OP_NORMAL
        |=> cmd_out == CMD_ACTIVATE && !mem_ready_out ##1 cmd_valid_out && !mem_ready_out)
        else $error("normal access did not hold off the next request");

    a_detect_mode: assert property (
        ce_in && ecc_mode == ECC_DETECT |=> ecc_gen_en_out && ecc_detect_en_out && !ecc_correct_en_out)
        else $error("detect mode enables wrong");

    a_correct_mode: assert property (
        ce_in && ecc_mode == ECC_CORRECT |=> ecc_gen_en_out && ecc_detect_en_out && ecc_correct_en_out)
        else $error("correct mode enables wrong");

    a_irq_multi: assert property (
        ce_in && ecc_multi_err_in && multi_err_irq_enable && !(wr_access && word_hit(paddr_in, ECCMODE_ADDR))
        |=> ecc_irq_out)
        else $error("enabled multiple error gave no interrupt");

    a_err_fields: assert property (
        ce_in && (ecc_single_err_in || ecc_multi_err_in)
        |=> err_check == $past(ecc_err_check_in) && err_synd == $past(ecc_syndrome_in))
        else $error("error check or syndrome not captured");

    c_mode_set: cover property (ce_in && accept && op_sel == OP_MODE_WRITE && mem_write_in);
    c_normal_rw: cover property (cmd_valid_out && cmd_out == CMD_WRITE);
    c_refresh: cover property (cmd_valid_out && cmd_out == CMD_REFRESH);
    c_irq: cover property (ecc_irq_out ##1 !ecc_irq_out);
    c_multi_err: cover property (ce_in && ecc_multi_err_in && multi_err_irq_enable);

endmodule
`default_nettype wire

// ===== tb/sdram_dimm_model.sv
// Behavioural model of the SDRAM DIMMs that records the commands they receive.
`timescale 1ns/10ps
`default_nettype none
module sdram_dimm_model
    import sdram_opm_pkg::*;
(
    // Clock and command bus.
    input  wire logic        core_clk_in,
    input  wire logic        cmd_valid_in,
    input  wire logic [2:0]  cmd_in,
    input  wire logic [1:0]  cmd_dimm_in,
    input  wire logic [12:0] cmd_addr_in
);
    int          count     = 0;
    int          refreshes = 0;
    logic [2:0]  last_cmd  = 3'h0;
    logic [2:0]  prev_cmd  = 3'h0;
    logic [1:0]  last_dimm = 2'h0;
    logic [12:0] mode_reg [4];

    // Each DIMM keeps its own mode register; refreshes are counted over all DIMMs together.
    always @(posedge core_clk_in) begin
        if (cmd_valid_in === 1'b1) begin
            count     <= count + 1;
            prev_cmd  <= last_cmd;
            last_cmd  <= cmd_in;
            last_dimm <= cmd_dimm_in;
            if (cmd_in == CMD_REFRESH) refreshes <= refreshes + 1;
            if (cmd_in == CMD_MODE_SET) mode_reg[cmd_dimm_in] <= cmd_addr_in;
        end
    end
endmodule
`default_nettype wire

// ===== tb/sdram_op_mode_ctrl_tb.sv
// Testbench of the SDRAM operation mode and ECC mode control block.
`timescale 1ns/10ps
`default_nettype none
module sdram_op_mode_ctrl_tb;
    import sdram_opm_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, mreq = 0, mwr = 0, sbe = 0, mbe = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, eaddr = 0, q;
    logic        pready, pslverr, mready, cv, ge, de, co, irq, e;
    logic [2:0]  cmd;
    logic [1:0]  cd, cb, mdimm = 0, mbank = 0;
    logic [12:0] ca, mrow = 0;
    logic [7:0]  wchk, echk = 0, synd = 0, gchk = 8'h3E;
    int          fail_count = 0, checked = 0, n;
    localparam logic [2:0] EXP [4] = '{3'h0, 3'h6, 3'h7, 3'h2};

    always #20 clk = ~clk;

    sdram_op_mode_ctrl dut (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .mem_req_in(mreq),
        .mem_write_in(mwr), .mem_dimm_in(mdimm), .mem_bank_in(mbank), .mem_row_in(mrow),
        .mem_ready_out(mready), .cmd_valid_out(cv), .cmd_out(cmd), .cmd_dimm_out(cd),
        .cmd_bank_out(cb), .cmd_addr_out(ca), .ecc_gen_check_in(gchk), .ecc_single_err_in(sbe),
        .ecc_multi_err_in(mbe), .ecc_err_check_in(echk), .ecc_syndrome_in(synd),
        .ecc_err_addr_in(eaddr), .ecc_gen_en_out(ge), .ecc_detect_en_out(de),
        .ecc_correct_en_out(co), .ecc_wr_check_out(wchk), .ecc_irq_out(irq));

    sdram_dimm_model dimms (.core_clk_in(clk), .cmd_valid_in(cv), .cmd_in(cmd), .cmd_dimm_in(cd),
        .cmd_addr_in(ca));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; pen <= 0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic experr);
        apb(0, a, 32'h0);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    task automatic mem(input logic w, input logic [1:0] d, input logic [12:0] r);
        @(posedge clk);
        mreq <= 1; mwr <= w; mdimm <= d; mbank <= 2'h1; mrow <= r;
        do @(posedge clk); while (mready !== 1'b1);
        mreq <= 0;
        repeat (3) @(posedge clk);
    endtask

    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        results();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        rd(OPMODE_ADDR, 32'h1, 0);
        rd(ECCMODE_ADDR, 32'h0, 0);
        rd(32'h1E00_0080, 32'h0, 1);
        rd(OPMODE_ADDR + 4, 32'h0, 0);
        mem(1, 0, 13'h0155);
        mem(0, 0, 13'h0155);
        chk(dimms.last_cmd, CMD_NOP);
        apb(1, OPMODE_ADDR, OP_PRECHARGE);
        mem(1, 2, 13'h0000);
        chk(dimms.last_cmd, CMD_PRECHARGE_ALL);
        chk(dimms.last_dimm, 2'h2);
        apb(1, OPMODE_ADDR, OP_REFRESH);
        n = dimms.refreshes;
        repeat (8) mem(1, 3, 13'h1FFF);
        mem(0, 3, 13'h1FFF);
        chk(32'(dimms.refreshes - n), 32'h8);
        apb(1, OPMODE_ADDR, OP_MODE_WRITE);
        mem(1, 1, 13'h0031);
        chk(dimms.mode_reg[1], 13'h0031);
        apb(1, OPMODE_ADDR, 32'h5);
        n = dimms.count;
        mem(1, 0, 13'h0031);
        chk(32'(dimms.count - n), 32'h0);
        apb(1, OPMODE_ADDR, 32'hFFFF_FFF8);
        n = dimms.count;
        mem(1, 2, 13'h0ABC);
        chk(32'(dimms.count - n), 32'h2);
        chk(dimms.prev_cmd, CMD_ACTIVATE);
        chk(dimms.last_cmd, CMD_WRITE);
        chk(cb, 2'h1);
        rd(OPMODE_ADDR, 32'h0, 0);
        for (int m = 0; m < 4; m++) begin
            apb(1, ECCMODE_ADDR, 32'(m));
            repeat (2) @(posedge clk);
            chk({29'h0, ge, de, co}, {29'h0, EXP[m]});
            chk(wchk, (m == 3) ? 8'h00 : 8'h3E);
        end
        apb(1, ECCMODE_ADDR, 32'hFFFF_A5E3);
        repeat (3) @(posedge clk);
        chk(wchk, 8'hA5);
        rd(ECCMODE_ADDR, 32'h0000_A503, 0);
        echk <= 8'h3C; synd <= 8'h5A; eaddr <= 32'h0123_456F; sbe <= 1;
        @(posedge clk);
        sbe <= 0;
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(ERRADDR_ADDR, 32'h0123_4560, 0);
        apb(1, ECCMODE_ADDR, 32'h0000_A50B);
        @(posedge clk);
        chk(irq, 1'b1);
        rd(ERRSTAT_ADDR, 32'h005A_3C01, 0);
        @(posedge clk);
        chk(irq, 1'b0);
        sbe <= 1'b1;
        @(posedge clk);
        sbe <= 1'b0;
        @(posedge clk);
        chk(irq, 1'b1);
        apb(1, ECCMODE_ADDR, 32'h0000_A513);
        @(posedge clk);
        chk(irq, 1'b0);
        mbe <= 1'b1;
        eaddr <= 32'h0ABC_DEF7;
        @(posedge clk);
        mbe <= 1'b0;
        @(posedge clk);
        chk(irq, 1'b1);
        rd(ERRADDR_ADDR, 32'h0ABC_DEF0, 0);
        rd(ERRSTAT_ADDR, 32'h005A_3C03, 0);
        results();
    end
endmodule
`default_nettype wire
